//--- rtl/acyclic_parameter_channel.sv
// Device-side acyclic parameter channel, breaker objects and run source selection
`timescale 1ns/100ps
`include "apc_map.svh"
module acyclic_parameter_channel (
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic WR_BYTE_VALID_IN,
  input wire apc_pkg::byte_t WR_BYTE_IN,
  input wire logic WR_LAST_IN,
  input wire apc_pkg::byte_t WR_INDEX_IN,
  input wire logic RD_REQ_IN,
  input wire apc_pkg::byte_t RD_INDEX_IN,
  input wire logic PAR_DONE_IN,
  input wire logic [31:0] PAR_RDATA_IN,
  input wire logic [15:0] PD_CTRL_IN,
  input wire apc_pkg::byte_t PROFILE_IN,
  input wire logic TERM_RUN_IN,
  input wire apc_pkg::byte_t RELATIVE_CURRENT_IN,
  input wire apc_pkg::byte_t THERMAL_IMAGE_IN,
  input wire apc_pkg::byte_t TRIP_SETTINGS_IN,
  output logic RSP_VALID_OUT,
  output logic RSP_WRITE_OUT,
  output logic RSP_OK_OUT,
  output apc_pkg::byte_t RSP_ERR_OUT,
  output apc_pkg::byte_t RSP_REF_OUT,
  output logic [2:0] RSP_LEN_OUT,
  output logic [31:0] RSP_DATA_OUT,
  output logic PAR_REQ_OUT,
  output logic PAR_WRITE_OUT,
  output logic [15:0] PAR_NUM_OUT,
  output logic [15:0] PAR_SUB_OUT,
  output logic [31:0] PAR_WDATA_OUT,
  output logic RUN_CMD_OUT,
  output logic TERMINAL_MODE_OUT
);
  import apc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Frame capture and job state
  job_state_t state, next_state;
  logic [4:0] count, next_count;
  logic overflow, next_overflow;
  byte_t ref_id, next_ref_id, frame_ref, next_frame_ref;
  byte_t job_type, next_job_type;
  logic frame_bad, next_frame_bad;
  logic [15:0] par_num, next_par_num;
  logic [15:0] sub, next_sub;
  logic [31:0] value, next_value;
  logic [31:0] result, next_result;
  logic [15:0] control_source, next_control_source;
  logic rsp_valid, next_rsp_valid;
  logic rsp_write, next_rsp_write;
  logic rsp_ok, next_rsp_ok;
  byte_t rsp_err, next_rsp_err;
  byte_t rsp_ref, next_rsp_ref;
  logic [2:0] rsp_len, next_rsp_len;
  logic [31:0] rsp_data, next_rsp_data;
  logic par_req, next_par_req, par_write, next_par_write;
  logic [4:0] frame_len;
  logic len_ok;

  function automatic logic is_bus_profile(input byte_t profile);
    return profile == 8'h07 || profile == 8'h08 || profile == 8'h09 || profile == 8'h0B;
  endfunction : is_bus_profile
  always_comb begin
    next_state = state;
    next_count = count;
    next_overflow = overflow;
    next_ref_id = ref_id;
    // Busy refusals must echo their own reference, not the pending job's
    next_frame_ref = (WR_BYTE_VALID_IN && count == `BYTE_REF) ? WR_BYTE_IN : frame_ref;
    next_job_type = job_type;
    next_frame_bad = frame_bad;
    next_par_num = par_num;
    next_sub = sub;
    next_value = value;
    next_result = result;
    next_control_source = control_source;
    next_rsp_valid = 1'b0;
    next_rsp_write = rsp_write;
    next_rsp_ok = rsp_ok;
    next_rsp_err = rsp_err;
    next_rsp_ref = rsp_ref;
    next_rsp_len = rsp_len;
    next_rsp_data = rsp_data;
    next_par_req = 1'b0;
    frame_len = count + 5'h01;
    len_ok = 1'b0;
    if (WR_BYTE_VALID_IN) begin
      // Fields are only captured while idle so a stray frame cannot corrupt a pending job
      if (state == JOB_IDLE) begin
        unique case (count)
          `BYTE_REF: next_ref_id = WR_BYTE_IN;
          `BYTE_TYPE: next_job_type = WR_BYTE_IN;
          `BYTE_OBJECT_ID: next_frame_bad = frame_bad | (WR_BYTE_IN != `OBJECT_ID_DRIVE);
          `BYTE_PAR_COUNT: next_frame_bad = frame_bad | (WR_BYTE_IN != `PAR_COUNT_ONE);
          `BYTE_PAR_NUM_HI: next_par_num = {WR_BYTE_IN, par_num[7:0]};
          `BYTE_PAR_NUM_LO: next_par_num = {par_num[15:8], WR_BYTE_IN};
          `BYTE_SUB_HI: next_sub = {WR_BYTE_IN, sub[7:0]};
          `BYTE_SUB_LO: next_sub = {sub[15:8], WR_BYTE_IN};
          default: begin
            // Value bytes shift in big-endian; only the last four are kept
            if (count >= `BYTE_VALUE_FIRST) begin
              next_value = {value[23:0], WR_BYTE_IN};
            end
          end
        endcase
        if (count == `BYTE_REF) begin
          next_frame_bad = 1'b0;
          next_value = 32'h0000_0000;
        end
      end
      if (count == `WRITE_JOB_MAX) begin
        next_overflow = 1'b1;
      end else begin
        next_count = frame_len;
      end
      if (WR_LAST_IN) begin
        next_count = 5'h00;
        next_overflow = 1'b0;
        next_rsp_valid = 1'b1;
        next_rsp_write = 1'b1;
        next_rsp_len = 3'h0;
        next_rsp_data = 32'h0000_0000;
        next_rsp_ref = next_frame_ref;
        if (next_job_type == `TYPE_READ) begin
          len_ok = frame_len == `READ_JOB_LEN;
        end else if (next_job_type == `TYPE_WRITE) begin
          len_ok = frame_len >= `WRITE_JOB_MIN && frame_len <= `WRITE_JOB_MAX && !overflow;
        end
        if (WR_INDEX_IN != `IDX_PARAM_CHANNEL) begin
          next_rsp_ok = 1'b0;
          next_rsp_err = `ERR_BAD_REQUEST;
        end else if (state != JOB_IDLE) begin
          next_rsp_ok = 1'b0;
          next_rsp_err = `ERR_STATE_CONFLICT;
        end else if (!len_ok || next_frame_bad || next_rsp_ref == 8'h00) begin
          next_rsp_ok = 1'b0;
          next_rsp_err = `ERR_BAD_REQUEST;
        end else begin
          next_rsp_ok = 1'b1;
          next_rsp_err = 8'h00;
          next_state = JOB_EXEC;
        end
      end
    end else if (RD_REQ_IN) begin
      next_rsp_valid = 1'b1;
      next_rsp_write = 1'b0;
      next_rsp_ok = 1'b1;
      next_rsp_err = 8'h00;
      next_rsp_len = 3'h1;
      next_rsp_ref = 8'h00;
      next_rsp_data = 32'h0000_0000;
      // Reads are never gated by the control source
      unique case (RD_INDEX_IN)
        `IDX_RELATIVE_CURRENT: next_rsp_data = {24'h00_0000, RELATIVE_CURRENT_IN};
        `IDX_THERMAL_IMAGE: next_rsp_data = {24'h00_0000, THERMAL_IMAGE_IN};
        `IDX_TRIP_SETTINGS: next_rsp_data = {24'h00_0000, TRIP_SETTINGS_IN};
        `IDX_PARAM_CHANNEL: begin
          next_rsp_ref = ref_id;
          if (state == JOB_READY) begin
            next_rsp_len = (job_type == `TYPE_READ) ? 3'h4 : 3'h0;
            next_rsp_data = (job_type == `TYPE_READ) ? result : 32'h0000_0000;
            next_state = JOB_IDLE;
          end else begin
            next_rsp_ok = 1'b0;
            next_rsp_err = `ERR_STATE_CONFLICT;
            next_rsp_len = 3'h0;
          end
        end
        default: begin
          next_rsp_ok = 1'b0;
          next_rsp_err = `ERR_BAD_REQUEST;
          next_rsp_len = 3'h0;
        end
      endcase
    end
    next_par_write = next_job_type == `TYPE_WRITE;
    unique case (state)
      JOB_IDLE: ;
      JOB_EXEC: begin
        // The control source lives here because it steers the run path directly
        if (par_num == `CONTROL_SOURCE_PARAM && sub == 16'h0000) begin
          if (job_type == `TYPE_WRITE) begin
            next_control_source = value[15:0];
          end
          next_result = {16'h0000, control_source};
          next_state = JOB_READY;
        end else begin
          next_par_req = 1'b1;
          next_state = JOB_WAIT;
        end
      end
      JOB_WAIT: begin
        if (PAR_DONE_IN) begin
          next_result = PAR_RDATA_IN;
          next_state = JOB_READY;
        end
      end
      JOB_READY: ;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      state <= JOB_IDLE;
      count <= 5'h00;
      overflow <= 1'b0;
      ref_id <= 8'h00;
      frame_ref <= 8'h00;
      job_type <= 8'h00;
      frame_bad <= 1'b0;
      par_num <= 16'h0000;
      sub <= 16'h0000;
      value <= 32'h0000_0000;
      result <= 32'h0000_0000;
      control_source <= `CONTROL_SOURCE_RESET;
      rsp_valid <= 1'b0;
      rsp_write <= 1'b0;
      rsp_ok <= 1'b0;
      rsp_err <= 8'h00;
      rsp_ref <= 8'h00;
      rsp_len <= 3'h0;
      rsp_data <= 32'h0000_0000;
      par_req <= 1'b0;
      par_write <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      overflow <= next_overflow;
      ref_id <= next_ref_id;
      frame_ref <= next_frame_ref;
      job_type <= next_job_type;
      frame_bad <= next_frame_bad;
      par_num <= next_par_num;
      sub <= next_sub;
      value <= next_value;
      result <= next_result;
      control_source <= next_control_source;
      rsp_valid <= next_rsp_valid;
      rsp_write <= next_rsp_write;
      rsp_ok <= next_rsp_ok;
      rsp_err <= next_rsp_err;
      rsp_ref <= next_rsp_ref;
      rsp_len <= next_rsp_len;
      rsp_data <= next_rsp_data;
      par_req <= next_par_req;
      par_write <= next_par_write;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run command source
  logic term_s1, term_s2, term_s3, term_run, next_term_run;
  logic run_cmd, next_run_cmd;
  logic terminal_mode, next_terminal_mode;

  always_comb begin
    // Pin is taken only once the last two sync stages agree, which filters one-cycle glitches
    next_term_run = (term_s2 == term_s3) ? term_s3 : term_run;
    next_terminal_mode = control_source == `CONTROL_SOURCE_TERMINAL;
    if (!next_terminal_mode && is_bus_profile(PROFILE_IN) && !PD_CTRL_IN[`BUS_CONTROL_BIT]) begin
      next_terminal_mode = 1'b1;
    end
    next_run_cmd = next_terminal_mode ? term_run : PD_CTRL_IN[`PD_RUN_BIT];
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      term_s1 <= 1'b0;
      term_s2 <= 1'b0;
      term_s3 <= 1'b0;
      term_run <= 1'b0;
      run_cmd <= 1'b0;
      terminal_mode <= 1'b0;
    end else begin
      term_s1 <= TERM_RUN_IN;
      term_s2 <= term_s1;
      term_s3 <= term_s2;
      term_run <= next_term_run;
      run_cmd <= next_run_cmd;
      terminal_mode <= next_terminal_mode;
    end
  end
  assign RSP_VALID_OUT = rsp_valid;
  assign RSP_WRITE_OUT = rsp_write;
  assign RSP_OK_OUT = rsp_ok;
  assign RSP_ERR_OUT = rsp_err;
  assign RSP_REF_OUT = rsp_ref;
  assign RSP_LEN_OUT = rsp_len;
  assign RSP_DATA_OUT = rsp_data;
  assign PAR_REQ_OUT = par_req;
  assign PAR_WRITE_OUT = par_write;
  assign PAR_NUM_OUT = par_num;
  assign PAR_SUB_OUT = sub;
  assign PAR_WDATA_OUT = value;
  assign RUN_CMD_OUT = run_cmd;
  assign TERMINAL_MODE_OUT = terminal_mode;
endmodule : acyclic_parameter_channel

//--- rtl/apc_map.svh
// Offsets, field positions, reset values and codes of the acyclic parameter channel
`ifndef APC_MAP_SVH
`define APC_MAP_SVH
`define IDX_RELATIVE_CURRENT 8'h01
`define IDX_THERMAL_IMAGE 8'h02
`define IDX_TRIP_SETTINGS 8'h03
`define IDX_PARAM_CHANNEL 8'h2F
`define BYTE_REF 5'h00
`define BYTE_TYPE 5'h01
`define BYTE_OBJECT_ID 5'h02
`define BYTE_PAR_COUNT 5'h03
`define BYTE_PAR_NUM_HI 5'h06
`define BYTE_PAR_NUM_LO 5'h07
`define BYTE_SUB_HI 5'h08
`define BYTE_SUB_LO 5'h09
`define BYTE_VALUE_FIRST 5'h0A
`define READ_JOB_LEN 5'h0A
`define WRITE_JOB_MIN 5'h0B
`define WRITE_JOB_MAX 5'h10
`define TYPE_READ 8'h01
`define TYPE_WRITE 8'h02
`define OBJECT_ID_DRIVE 8'h00
`define PAR_COUNT_ONE 8'h01
`define CONTROL_SOURCE_PARAM 16'h03A0
`define CONTROL_SOURCE_RESET 16'h0001
`define CONTROL_SOURCE_TERMINAL 16'h0000
`define BUS_CONTROL_BIT 10
`define PD_RUN_BIT 0
`define ERR_STATE_CONFLICT 8'h01
`define ERR_BAD_REQUEST 8'h02
`endif

//--- rtl/apc_pkg.sv
// Types shared by the acyclic parameter channel
package apc_pkg;
  typedef enum logic [1:0] {JOB_IDLE, JOB_EXEC, JOB_WAIT, JOB_READY} job_state_t;
  typedef logic [7:0] byte_t;
endpackage : apc_pkg

//--- verif/apc_properties.sv
// Port checker for the acyclic parameter channel
`timescale 1ns/100ps
module apc_properties (
  input wire logic CLK_IN, SRST_IN, WR_BYTE_VALID_IN, WR_LAST_IN, RD_REQ_IN,
  input wire logic RSP_VALID_OUT, RSP_WRITE_OUT, RSP_OK_OUT, PAR_REQ_OUT, PAR_WRITE_OUT,
  input wire logic TERMINAL_MODE_OUT,
  input wire apc_pkg::byte_t RD_INDEX_IN, RELATIVE_CURRENT_IN, PROFILE_IN, RSP_ERR_OUT,
  input wire logic [15:0] PD_CTRL_IN, PAR_NUM_OUT,
  input wire logic [2:0] RSP_LEN_OUT,
  input wire logic [31:0] RSP_DATA_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  wire logic rd_take = RD_REQ_IN && !WR_BYTE_VALID_IN;
  AST_WR_ANSWER: assert property (
    WR_BYTE_VALID_IN && WR_LAST_IN |=> RSP_VALID_OUT && RSP_WRITE_OUT)
    else $error("write frame not answered");
  AST_WR_NO_DATA: assert property (
    RSP_VALID_OUT && RSP_WRITE_OUT |-> RSP_LEN_OUT == 3'h0 && RSP_DATA_OUT == 32'h0)
    else $error("write answer carries data");
  AST_RD_ANSWER: assert property (
    rd_take |=> RSP_VALID_OUT && !RSP_WRITE_OUT)
    else $error("read request not answered");
  AST_NEG_CODE: assert property (
    RSP_VALID_OUT && !RSP_OK_OUT |-> RSP_ERR_OUT inside {8'h01, 8'h02} && RSP_LEN_OUT == 3'h0)
    else $error("negative answer malformed");
  AST_POS_CODE: assert property (
    RSP_VALID_OUT && RSP_OK_OUT |-> RSP_ERR_OUT == 8'h00)
    else $error("positive answer has error code");
  AST_BREAKER: assert property (
    rd_take && RD_INDEX_IN == 8'h01 |=> RSP_OK_OUT && RSP_LEN_OUT == 3'h1
    && RSP_DATA_OUT[7:0] == $past(RELATIVE_CURRENT_IN)) else $error("current object wrong");
  AST_PROFILE_BIT: assert property (
    PROFILE_IN inside {8'h07, 8'h08, 8'h09, 8'h0B} && !PD_CTRL_IN[10] |=> TERMINAL_MODE_OUT)
    else $error("bus control bit ignored");
  AST_JOB_FIELDS: assert property (
    PAR_REQ_OUT |=> !PAR_REQ_OUT && $stable(PAR_NUM_OUT) && $stable(PAR_WRITE_OUT))
    else $error("job fields moved after start");
  cover property (rd_take && RD_INDEX_IN == 8'h2F ##1 RSP_OK_OUT);
  cover property (RSP_VALID_OUT && RSP_ERR_OUT == 8'h01);
  cover property (PAR_REQ_OUT && PAR_WRITE_OUT);
endmodule : apc_properties
bind acyclic_parameter_channel apc_properties chk (.*);

//--- verif/param_store_model.sv
// Parameter store answering channel jobs after a set latency
`timescale 1ns/100ps
module param_store_model (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic req_in,
  input wire logic [15:0] num_in,
  input wire logic [15:0] sub_in,
  input wire logic [7:0] lat_in,
  output logic done_out = 1'b0,
  output logic [31:0] rdata_out = 32'h0
);
  int cnt = -1;
  // Data toggles outside the done pulse so a stale value cannot pass
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (srst_in) cnt <= -1;
    else if (req_in) cnt <= lat_in;
    else if (cnt > 0) cnt <= cnt - 1;
    else if (cnt == 0) begin
      done_out <= 1'b1;
      rdata_out <= {num_in, sub_in};
      cnt <= -1;
    end
  end
endmodule : param_store_model

//--- verif/test_acyclic_parameter_channel.sv
// Self-checking bench for the acyclic parameter channel
`timescale 1ns/100ps
`include "apc_map.svh"
module test_acyclic_parameter_channel;
  import apc_pkg::*;
  logic CLK_IN = 0, SRST_IN = 1, WR_BYTE_VALID_IN = 0, WR_LAST_IN = 0, RD_REQ_IN = 0;
  logic PAR_DONE_IN, TERM_RUN_IN = 0, RSP_VALID_OUT, RSP_WRITE_OUT, RSP_OK_OUT;
  logic PAR_REQ_OUT, PAR_WRITE_OUT, RUN_CMD_OUT, TERMINAL_MODE_OUT;
  byte_t WR_BYTE_IN = 0, WR_INDEX_IN = 0, RD_INDEX_IN = 0, PROFILE_IN = 0;
  byte_t RELATIVE_CURRENT_IN = 8'h9C, THERMAL_IMAGE_IN = 8'h41, TRIP_SETTINGS_IN = 8'h1D;
  byte_t RSP_ERR_OUT, RSP_REF_OUT;
  logic [2:0] RSP_LEN_OUT;
  logic [15:0] PD_CTRL_IN = 16'h0, PAR_NUM_OUT, PAR_SUB_OUT;
  logic [31:0] PAR_RDATA_IN, RSP_DATA_OUT, PAR_WDATA_OUT;
  logic [7:0] lat = 8'h14;
  int err_total = 0, tests_run = 0;
  byte_t f [18];
  byte_t prof [5] = '{8'h07, 8'h08, 8'h09, 8'h0B, 8'h03};
  acyclic_parameter_channel dut (.*);
  param_store_model store (.clk_in(CLK_IN), .srst_in(SRST_IN), .req_in(PAR_REQ_OUT),
    .num_in(PAR_NUM_OUT), .sub_in(PAR_SUB_OUT), .lat_in(lat), .done_out(PAR_DONE_IN),
    .rdata_out(PAR_RDATA_IN));
  always #4 CLK_IN = ~CLK_IN;
  //////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  task automatic rsp(input logic ok, wr, input byte_t err, rf, input logic [2:0] len,
      input logic [31:0] d);
    chk({RSP_VALID_OUT, RSP_WRITE_OUT, RSP_OK_OUT, RSP_LEN_OUT, RSP_ERR_OUT, RSP_REF_OUT,
      RSP_DATA_OUT}, {1'b1, wr, ok, len, err, rf, d});
  endtask : rsp
  task automatic build(input byte_t rf, ty, input logic [15:0] par_num, sub,
      input logic [31:0] v, input int n);
    f = '{default: 8'h00};
    {f[0], f[1], f[3], f[4], f[5]} = {rf, ty, 24'h011001};
    {f[6], f[7], f[8], f[9]} = {par_num, sub};
    for (int i = 10; i < n; i++) f[i] = byte_t'(v >> (8 * (n - 1 - i)));
  endtask : build
  // One idle edge before each request; on return the one-cycle answer still stands
  task automatic send(input int n, input byte_t idx);
    @(negedge CLK_IN);
    for (int i = 0; i < n; i++) begin
      {WR_BYTE_VALID_IN, WR_BYTE_IN, WR_LAST_IN, WR_INDEX_IN} = {1'b1, f[i], i == n - 1, idx};
      @(negedge CLK_IN);
    end
    {WR_BYTE_VALID_IN, WR_LAST_IN, WR_BYTE_IN} = {2'b00, ~WR_BYTE_IN};
  endtask : send
  task automatic rd(input byte_t idx);
    @(negedge CLK_IN);
    {RD_REQ_IN, RD_INDEX_IN} = {1'b1, idx};
    @(negedge CLK_IN);
    {RD_REQ_IN, RD_INDEX_IN} = {1'b0, ~idx};
  endtask : rd
  task automatic poll(input byte_t rf, input logic [2:0] len, input logic [31:0] d);
    int k = 0;
    do begin
      rd(`IDX_PARAM_CHANNEL);
      k++;
      if (RSP_OK_OUT !== 1'b1) rsp(0, 0, `ERR_STATE_CONFLICT, rf, 0, 0);
    end while (RSP_OK_OUT !== 1'b1 && k < 80);
    rsp(1, 0, 0, rf, len, d);
  endtask : poll
  task automatic job(input byte_t rf, ty, input logic [15:0] par_num, sub,
      input logic [31:0] v, input int n, input logic [2:0] len, input logic [31:0] d);
    build(rf, ty, par_num, sub, v, n);
    send(n, `IDX_PARAM_CHANNEL);
    rsp(1, 1, 0, rf, 0, 0);
    @(negedge CLK_IN);
    if (par_num != `CONTROL_SOURCE_PARAM) begin
      chk({PAR_REQ_OUT, PAR_WRITE_OUT, PAR_NUM_OUT, PAR_SUB_OUT}, {1'b1, ty == 2, par_num, sub});
      if (ty == `TYPE_WRITE) chk(PAR_WDATA_OUT, v);
      rd(`IDX_PARAM_CHANNEL);
      rsp(0, 0, `ERR_STATE_CONFLICT, rf, 0, 0);
    end
    poll(rf, len, d);
  endtask : job
  task automatic refuse(input byte_t rf, ty, input int n);
    build(rf, ty, 16'h0100, 0, 0, n);
    send(n, `IDX_PARAM_CHANNEL);
    rsp(0, 1, `ERR_BAD_REQUEST, rf, 0, 0);
  endtask : refuse
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  initial begin
    #400000;
    err_total++;
    final_report();
  end
  initial begin
    repeat (8) @(negedge CLK_IN);
    SRST_IN = 0;
    chk({RSP_VALID_OUT, PAR_REQ_OUT, TERMINAL_MODE_OUT, RUN_CMD_OUT}, 0);
    job(8'h01, `TYPE_READ, 16'h0123, 16'h0002, 0, 10, 4, 32'h01230002);
    lat = 8'h03;
    job(8'hFF, `TYPE_WRITE, 16'h0456, 16'h0001, 32'h11223344, 14, 0, 0);
    $display("test 1 done");
    lat = 8'h30;
    build(8'h22, `TYPE_READ, 16'h0007, 0, 0, 10);
    send(10, `IDX_PARAM_CHANNEL);
    rsp(1, 1, 0, 8'h22, 0, 0);
    build(8'h23, `TYPE_READ, 16'h0008, 0, 0, 10);
    send(10, `IDX_PARAM_CHANNEL);
    rsp(0, 1, `ERR_STATE_CONFLICT, 8'h23, 0, 0);
    poll(8'h22, 4, 32'h00070000);
    refuse(8'h00, `TYPE_READ, 10);
    refuse(8'h31, 8'h03, 10);
    refuse(8'h32, `TYPE_READ, 11);
    refuse(8'h33, `TYPE_WRITE, 17);
    refuse(8'h34, `TYPE_WRITE, 10);
    rd(8'h04);
    chk({RSP_OK_OUT, RSP_ERR_OUT}, {1'b0, `ERR_BAD_REQUEST});
    $display("test 2 done");
    job(8'h40, `TYPE_WRITE, `CONTROL_SOURCE_PARAM, 0, 0, 11, 0, 0);
    TERM_RUN_IN = 1;
    repeat (6) @(negedge CLK_IN);
    chk({TERMINAL_MODE_OUT, RUN_CMD_OUT}, 2'b11);
    job(8'h41, `TYPE_READ, `CONTROL_SOURCE_PARAM, 0, 0, 10, 4, 0);
    for (int i = 1; i < 4; i++) begin
      rd(byte_t'(i));
      rsp(1, 0, 0, 0, 1, {24'h0, i == 1 ? RELATIVE_CURRENT_IN : i == 2 ? THERMAL_IMAGE_IN
        : TRIP_SETTINGS_IN});
    end
    TERM_RUN_IN = 0;
    job(8'h42, `TYPE_WRITE, `CONTROL_SOURCE_PARAM, 0, 1, 11, 0, 0);
    $display("test 3 done");
    PD_CTRL_IN = 16'h0001;
    for (int i = 0; i < 10; i++) begin
      {PD_CTRL_IN[10], PROFILE_IN} = {i > 4, prof[i % 5]};
      repeat (3) @(negedge CLK_IN);
      chk({TERMINAL_MODE_OUT, RUN_CMD_OUT}, i < 4 ? 2'b10 : 2'b01);
    end
    $display("test 4 done");
    final_report();
  end
endmodule : test_acyclic_parameter_channel
